/* File: logic/pfdc_top.v */
/*
 * PLL feedback divider configuration: four 40-bit registers reached over
 * the serial port, decoded divider settings for both PLLs, PLL2 power
 * gating and the shared serial-out / loss-of-lock pin.
 * Assumes serial pins and the lock and power-down inputs are synchronous
 * to core_clk; the pin wire level is resolved outside from its enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfdc_map.vh"

module pfdc_top (
	input wire core_clk,
	input wire rst,
	input wire sclk,
	input wire cs_n,
	input wire mosi,
	input wire [1:0] pll_power_down_pin,
	input wire pll2_locked,
	output reg serial_out_or_unlock_pin_o,
	output reg serial_out_or_unlock_pin_oe_n,
	output reg loss_of_lock_flag,
	output reg detector_pump_power_en,
	output reg oscillator_power_en,
	output reg feedback_div_power_en,
	output reg [1:0] pll1_mode,
	output reg [7:0] pll1_ratio_int,
	output reg [27:0] pll1_ratio_num,
	output reg [15:0] pll1_ratio_den,
	output reg pll1_exact_ratio,
	output reg [2:0] pll1_interp_code,
	output reg [2:0] pll1_mash_code,
	output reg pll1_bad_cfg,
	output reg [1:0] pll2_mode,
	output reg [7:0] pll2_ratio_int,
	output reg [27:0] pll2_ratio_num,
	output reg [15:0] pll2_ratio_den,
	output reg pll2_exact_ratio,
	output reg [2:0] pll2_interp_code,
	output reg [2:0] pll2_mash_code,
	output reg pll2_bad_cfg
);
	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	reg [39:0] pll1_divider_config;
	reg [39:0] pll1_modulus_mode_config;
	reg [39:0] pll2_divider_and_power_config;
	reg [39:0] pll2_modulus_mode_config;
	reg [39:0] rd_data;

	wire [6:0] addr;
	wire wr_en;
	wire [39:0] wr_data;
	wire sdo_bit;
	wire sdo_active;

	pfdc_spi_slave u_spi (
		.core_clk(core_clk),
		.rst(rst),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.rd_data(rd_data),
		.addr(addr),
		.wr_en(wr_en),
		.wr_data(wr_data),
		.sdo_bit(sdo_bit),
		.sdo_active(sdo_active)
	);

	// full 40-bit writes only; the host owns legality of the values written
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pll1_divider_config <= `PFDC_RST_DIV;
			pll1_modulus_mode_config <= `PFDC_RST_MODE;
			// RULE10 RULE11 RULE12 power bits reset high
			pll2_divider_and_power_config <= `PFDC_RST_PLL2_DIV;
			pll2_modulus_mode_config <= `PFDC_RST_MODE;
		end else if (wr_en) begin
			case (addr)
				`PFDC_ADDR_PLL1_DIV: pll1_divider_config <= wr_data;
				`PFDC_ADDR_PLL1_MODE: pll1_modulus_mode_config <= wr_data;
				`PFDC_ADDR_PLL2_DIV: pll2_divider_and_power_config <= wr_data;
				`PFDC_ADDR_PLL2_MODE: pll2_modulus_mode_config <= wr_data;
				default: ;
			endcase
		end
	end

	// readback mux; unmapped addresses read zero
	always @* begin
		case (addr)
			`PFDC_ADDR_PLL1_DIV: rd_data = pll1_divider_config;
			`PFDC_ADDR_PLL1_MODE: rd_data = pll1_modulus_mode_config;
			`PFDC_ADDR_PLL2_DIV: rd_data = pll2_divider_and_power_config;
			`PFDC_ADDR_PLL2_MODE: rd_data = pll2_modulus_mode_config;
			default: rd_data = 40'h00_0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// divider decode, one per PLL
	// ----------------------------------------------------------------
	wire [1:0] d1_mode;
	wire [7:0] d1_int;
	wire [27:0] d1_num;
	wire [15:0] d1_den;
	wire d1_exact;
	wire [2:0] d1_interp;
	wire [2:0] d1_mash;
	wire d1_bad;
	wire [1:0] d2_mode;
	wire [7:0] d2_int;
	wire [27:0] d2_num;
	wire [15:0] d2_den;
	wire d2_exact;
	wire [2:0] d2_interp;
	wire [2:0] d2_mash;
	wire d2_bad;

	pfdc_ratio_decode u_dec1 (
		.div_reg(pll1_divider_config),
		.mode_reg(pll1_modulus_mode_config),
		.mode(d1_mode),
		.ratio_int(d1_int),
		.ratio_num(d1_num),
		.ratio_den(d1_den),
		.exact_ratio(d1_exact),
		.interp_code(d1_interp),
		.mash_code(d1_mash),
		.bad_cfg(d1_bad)
	);

	pfdc_ratio_decode u_dec2 (
		.div_reg(pll2_divider_and_power_config),
		.mode_reg(pll2_modulus_mode_config),
		.mode(d2_mode),
		.ratio_int(d2_int),
		.ratio_num(d2_num),
		.ratio_den(d2_den),
		.exact_ratio(d2_exact),
		.interp_code(d2_interp),
		.mash_code(d2_mash),
		.bad_cfg(d2_bad)
	);

	// decoded settings are registered so the analog side never sees decode glitches
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pll1_mode <= `PFDC_MODE_FRAC;
			pll1_ratio_int <= 8'h00;
			pll1_ratio_num <= 28'h000_0000;
			pll1_ratio_den <= 16'h0000;
			pll1_exact_ratio <= 1'b0;
			pll1_interp_code <= 3'h0;
			pll1_mash_code <= 3'h0;
			pll1_bad_cfg <= 1'b0;
			pll2_mode <= `PFDC_MODE_FRAC;
			pll2_ratio_int <= 8'h00;
			pll2_ratio_num <= 28'h000_0000;
			pll2_ratio_den <= 16'h0000;
			pll2_exact_ratio <= 1'b0;
			pll2_interp_code <= 3'h0;
			pll2_mash_code <= 3'h0;
			pll2_bad_cfg <= 1'b0;
		end else begin
			pll1_mode <= d1_mode;
			pll1_ratio_int <= d1_int;
			pll1_ratio_num <= d1_num;
			pll1_ratio_den <= d1_den;
			pll1_exact_ratio <= d1_exact;
			pll1_interp_code <= d1_interp;
			pll1_mash_code <= d1_mash;
			pll1_bad_cfg <= d1_bad;
			pll2_mode <= d2_mode;
			pll2_ratio_int <= d2_int;
			pll2_ratio_num <= d2_num;
			pll2_ratio_den <= d2_den;
			pll2_exact_ratio <= d2_exact;
			pll2_interp_code <= d2_interp;
			pll2_mash_code <= d2_mash;
			pll2_bad_cfg <= d2_bad;
		end
	end

	// ----------------------------------------------------------------
	// PLL2 power gating
	// ----------------------------------------------------------------
	wire pll2_down;

	assign pll2_down = pll_power_down_pin[1];

	// RULE13 pin overrides bits
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detector_pump_power_en <= 1'b0;
			oscillator_power_en <= 1'b0;
			feedback_div_power_en <= 1'b0;
		end else begin
			// RULE10 detector pump gate
			detector_pump_power_en <= pll2_divider_and_power_config[`PFDC_PFD_EN_BIT] & ~pll2_down;
			// RULE11 oscillator gate
			oscillator_power_en <= pll2_divider_and_power_config[`PFDC_VCO_EN_BIT] & ~pll2_down;
			// RULE12 divider gate
			feedback_div_power_en <= pll2_divider_and_power_config[`PFDC_FBDIV_EN_BIT] & ~pll2_down;
		end
	end

	// ----------------------------------------------------------------
	// shared serial-out / loss-of-lock pin
	// ----------------------------------------------------------------
	wire unlock_sel;

	assign unlock_sel = pll2_divider_and_power_config[`PFDC_PIN_SEL_BIT];

	// in unlock function the pin is always driven, so readback is lost there
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			loss_of_lock_flag <= 1'b0;
			serial_out_or_unlock_pin_o <= 1'b0;
			serial_out_or_unlock_pin_oe_n <= 1'b1;
		end else begin
			// RULE16 unlock indication
			loss_of_lock_flag <= ~pll2_locked;
			// RULE14 pin function select
			if (unlock_sel) begin
				serial_out_or_unlock_pin_o <= ~pll2_locked;
				serial_out_or_unlock_pin_oe_n <= 1'b0;
			end else begin
				serial_out_or_unlock_pin_o <= sdo_bit;
				serial_out_or_unlock_pin_oe_n <= ~sdo_active;
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/pfdc_map.vh */
/*
 * Register map, field positions, reset values and mode codes of the PLL
 * feedback divider configuration block.
 * Assumes it is included by bare name from the design files that need it.
 */
// How it works
// RULE1: zero modulus makes the fractional field a 28-bit fixed-point fraction.
// RULE2: rational mode, nonzero modulus, select 3: ratio is integer plus numerator/modulus.
// RULE3: host must never program a numerator above the modulus.
// RULE4: PLL1 field bits 9:0 hold modulus bits 15:6.
// RULE5: low six modulus bits share bits 9:4 with fractional bits 5:0.
// RULE6: host writes PLL2 integer part in bits 39:32, value 23 or more.
// RULE7: bits 31:10 are fractional bits 27:6; fractional mode uses all 28.
// RULE8: integer mode routes top three fractional bits to interpolation or modulator.
// RULE9: host should not write the shared low bits as zero in integer mode.
// RULE10: bit 3 powers detector and charge pump, resets to 1.
// RULE11: bit 2 powers the oscillator, resets to 1.
// RULE12: bit 1 powers the feedback divider, resets to 1.
// RULE13: power-down pin forces detector, pump, oscillator and divider off.
// RULE14: bit 0 selects shared pin: 0 serial read data, 1 loss-of-lock.
// RULE15: a dedicated bit selects rational mode: numerator over modulus.
// RULE16: in unlock function the pin shows active while the PLL is unlocked.
`ifndef PFDC_MAP_VH
`define PFDC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PFDC_ADDR_PLL1_DIV 7'h06
`define PFDC_ADDR_PLL1_MODE 7'h07
`define PFDC_ADDR_PLL2_DIV 7'h08
`define PFDC_ADDR_PLL2_MODE 7'h09

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFDC_INT_MSB 39
`define PFDC_INT_LSB 32
`define PFDC_FRAC_MSB 31
`define PFDC_FRAC_LSB 4
`define PFDC_MODHI_MSB 9
`define PFDC_MODHI_LSB 0
`define PFDC_RATIONAL_BIT 10
`define PFDC_INTMODE_BIT 11
`define PFDC_SSEL_MSB 17
`define PFDC_SSEL_LSB 16
`define PFDC_PFD_EN_BIT 3
`define PFDC_VCO_EN_BIT 2
`define PFDC_FBDIV_EN_BIT 1
`define PFDC_PIN_SEL_BIT 0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PFDC_RST_DIV 40'h00_0000_0000
`define PFDC_RST_PLL2_DIV 40'h00_0000_000E
`define PFDC_RST_MODE 40'h00_0000_0000
`define PFDC_INT_MIN 8'h17
`define PFDC_SSEL_NO_INTERP 2'h3

// ----------------------------------------------------------------
// divider modes and serial framing
// ----------------------------------------------------------------
`define PFDC_MODE_INT 2'h0
`define PFDC_MODE_FRAC 2'h1
`define PFDC_MODE_RAT 2'h2
`define PFDC_FRAME_BITS 6'h30
`define PFDC_CMD_BITS 6'h08

`endif

/* File: logic/pfdc_spi_slave.v */
/*
 * Serial register port: command byte (bit 7 read, bits 6:0 address) then
 * 40 data bits, most significant first.
 * Assumes sclk, cs_n and mosi are synchronous to core_clk and each sclk
 * half period spans at least three core_clk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfdc_map.vh"

module pfdc_spi_slave (
	input wire core_clk,
	input wire rst,
	input wire sclk,
	input wire cs_n,
	input wire mosi,
	input wire [39:0] rd_data,
	output reg [6:0] addr,
	output reg wr_en,
	output reg [39:0] wr_data,
	output wire sdo_bit,
	output reg sdo_active
);
	reg sclk_q;
	reg [5:0] bit_cnt;
	reg [39:0] in_sr;
	reg [39:0] out_sr;
	reg is_read;
	reg load_pending;
	wire rise;
	wire fall;

	assign rise = sclk & ~sclk_q & ~cs_n;
	assign fall = ~sclk & sclk_q & ~cs_n;
	assign sdo_bit = out_sr[39];

	// ----------------------------------------------------------------
	// frame shifter
	// ----------------------------------------------------------------
	// read data is loaded one cycle after the command byte so the address is settled
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			bit_cnt <= 6'h00;
			in_sr <= 40'h00_0000_0000;
			out_sr <= 40'h00_0000_0000;
			is_read <= 1'b0;
			load_pending <= 1'b0;
			addr <= 7'h00;
			wr_en <= 1'b0;
			wr_data <= 40'h00_0000_0000;
			sdo_active <= 1'b0;
		end else begin
			sclk_q <= sclk;
			wr_en <= 1'b0;
			load_pending <= 1'b0;
			if (cs_n) begin
				bit_cnt <= 6'h00;
				sdo_active <= 1'b0;
			end else if (rise) begin
				in_sr <= {in_sr[38:0], mosi};
				if (bit_cnt != `PFDC_FRAME_BITS)
					bit_cnt <= bit_cnt + 6'h01;
				if (bit_cnt == `PFDC_CMD_BITS - 6'h01) begin
					is_read <= in_sr[6];
					addr <= {in_sr[5:0], mosi};
					load_pending <= in_sr[6];
				end
				// a write commits only on the last bit of a full frame
				if (bit_cnt == `PFDC_FRAME_BITS - 6'h01 && !is_read) begin
					wr_en <= 1'b1;
					wr_data <= {in_sr[38:0], mosi};
				end
			end else if (load_pending) begin
				out_sr <= rd_data;
			end else if (fall && is_read && bit_cnt > `PFDC_CMD_BITS) begin
				out_sr <= {out_sr[38:0], 1'b0};
			end
			if (load_pending)
				sdo_active <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: logic/pfdc_ratio_decode.v */
/*
 * Combinational decode of one PLL's divider and mode fields into the form
 * the divider uses. Assumes the caller registers the outputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfdc_map.vh"

module pfdc_ratio_decode (
	input wire [39:0] div_reg,
	input wire [39:0] mode_reg,
	output reg [1:0] mode,
	output wire [7:0] ratio_int,
	output reg [27:0] ratio_num,
	output reg [15:0] ratio_den,
	output wire exact_ratio,
	output reg [2:0] interp_code,
	output reg [2:0] mash_code,
	output wire bad_cfg
);
	wire [27:0] frac;
	wire [15:0] modulus;
	wire [1:0] s_sel;
	wire rational;
	wire int_mode;

	assign frac = div_reg[`PFDC_FRAC_MSB:`PFDC_FRAC_LSB];
	// RULE4 RULE5 modulus assembly
	assign modulus = {mode_reg[`PFDC_MODHI_MSB:`PFDC_MODHI_LSB], frac[5:0]};
	assign s_sel = mode_reg[`PFDC_SSEL_MSB:`PFDC_SSEL_LSB];
	assign rational = mode_reg[`PFDC_RATIONAL_BIT];
	assign int_mode = mode_reg[`PFDC_INTMODE_BIT];
	assign ratio_int = div_reg[`PFDC_INT_MSB:`PFDC_INT_LSB];

	// RULE2 exact ratio flag
	assign exact_ratio = (mode == `PFDC_MODE_RAT) && (s_sel == `PFDC_SSEL_NO_INTERP);
	// RULE3 RULE6 flag illegal host settings
	assign bad_cfg = (ratio_int < `PFDC_INT_MIN) ||
		((mode == `PFDC_MODE_RAT) && ({12'h000, frac[24:9]} > {12'h000, modulus}));

	// mode selection and field routing
	always @* begin
		mode = `PFDC_MODE_FRAC;
		ratio_num = frac;
		ratio_den = 16'h0000;
		interp_code = 3'h0;
		mash_code = 3'h0;
		if (int_mode) begin
			// RULE8 top bits routing; RULE9 shared bits ignored here
			mode = `PFDC_MODE_INT;
			ratio_num = 28'h000_0000;
			if (s_sel == `PFDC_SSEL_NO_INTERP)
				mash_code = frac[27:25];
			else
				interp_code = frac[27:25];
		end else if (rational && modulus != 16'h0000) begin
			// RULE15 RULE2 numerator over modulus
			mode = `PFDC_MODE_RAT;
			ratio_num = {12'h000, frac[24:9]};
			ratio_den = modulus;
		end
		// RULE1 RULE7 zero modulus keeps all 28 bits as fixed point
	end
endmodule
`default_nettype wire

/* File: verification/pfdc_top_chk.sv */
/* checker for pfdc_top ports: power gating, unlock flag, decode consistency.
   assumes one core_clk domain with async active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module pfdc_chk (
	input wire core_clk,
	input wire rst,
	input wire [1:0] pll_power_down_pin,
	input wire pll2_locked,
	input wire loss_of_lock_flag,
	input wire detector_pump_power_en,
	input wire oscillator_power_en,
	input wire feedback_div_power_en,
	input wire [1:0] pll1_mode,
	input wire [27:0] pll1_ratio_num,
	input wire [15:0] pll1_ratio_den,
	input wire [2:0] pll1_interp_code,
	input wire [2:0] pll1_mash_code,
	input wire [1:0] pll2_mode,
	input wire [7:0] pll2_ratio_int,
	input wire [27:0] pll2_ratio_num,
	input wire [15:0] pll2_ratio_den,
	input wire pll2_exact_ratio,
	input wire [2:0] pll2_interp_code,
	input wire [2:0] pll2_mash_code,
	input wire pll2_bad_cfg
);
	// ------
	// checks
	// ------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	reg live;
	// live lags reset by one edge so reset-time values never feed a lagged check
	always @(posedge core_clk or posedge rst) begin
		if (rst) live <= 1'b0;
		else live <= 1'b1;
	end
	AST_PD_OFF: assert property (live && pll_power_down_pin[1] |=>
		!detector_pump_power_en && !oscillator_power_en && !feedback_div_power_en)
		else $error("power enable high under power-down");
	AST_LOL_SET: assert property (live && !pll2_locked |=> loss_of_lock_flag)
		else $error("unlock flag low while unlocked");
	AST_LOL_CLR: assert property (live && pll2_locked |=> !loss_of_lock_flag)
		else $error("unlock flag high while locked");
	AST_BAD_CFG: assert property (live |-> pll2_bad_cfg == (pll2_ratio_int < 8'h17 ||
		(pll2_mode == 2'h2 && pll2_ratio_num > {12'h000, pll2_ratio_den})))
		else $error("bad config flag wrong");
	AST_RAT_DEN: assert property (live && pll1_mode == 2'h2 |->
		pll1_ratio_den != 16'h0000 && pll1_ratio_num[27:16] == 12'h000)
		else $error("rational mode with zero modulus");
	AST_FRAC: assert property (live && pll2_mode == 2'h1 |-> pll2_ratio_den == 16'h0000 &&
		pll2_interp_code == 3'h0 && pll2_mash_code == 3'h0 && !pll2_exact_ratio)
		else $error("fixed point mode carries rational or integer fields");
	AST_INT: assert property (live && pll1_mode == 2'h0 |->
		pll1_ratio_num == 28'h000_0000 && (pll1_interp_code == 3'h0 || pll1_mash_code == 3'h0))
		else $error("integer mode fields wrong");
	AST_EXACT: assert property (live && pll2_exact_ratio |-> pll2_mode == 2'h2)
		else $error("exact ratio outside rational mode");
	// main scenarios reached
	cover property (pll2_mode == 2'h2 && pll2_exact_ratio);
	cover property (pll1_mode == 2'h0 && pll1_mash_code != 3'h0);
	cover property (live && pll_power_down_pin[1]);
endmodule
bind pfdc_top pfdc_chk u_chk (.core_clk, .rst, .pll_power_down_pin, .pll2_locked, .loss_of_lock_flag,
	.detector_pump_power_en, .oscillator_power_en, .feedback_div_power_en, .pll1_mode, .pll1_ratio_num,
	.pll1_ratio_den, .pll1_interp_code, .pll1_mash_code, .pll2_mode, .pll2_ratio_int, .pll2_ratio_num,
	.pll2_ratio_den, .pll2_exact_ratio, .pll2_interp_code, .pll2_mash_code, .pll2_bad_cfg);
`default_nettype wire

/* File: verification/pfdc_top_bench.sv */
/* self-checking bench for pfdc_top: serial frames in, readback and decoded outputs compared.
   assumes the checker file is compiled alongside; pin level taken from o when oe_n is low. */
`timescale 1ns/1ps
`default_nettype none
module pfdc_top_bench;
	logic core_clk, rst, sclk, cs_n, mosi, pll2_locked, sclk_q;
	logic [1:0] pll_power_down_pin;
	wire serial_out_or_unlock_pin_o, serial_out_or_unlock_pin_oe_n, loss_of_lock_flag;
	wire detector_pump_power_en, oscillator_power_en, feedback_div_power_en;
	wire pll1_exact_ratio, pll1_bad_cfg, pll2_exact_ratio, pll2_bad_cfg;
	wire [1:0] pll1_mode, pll2_mode;
	wire [7:0] pll1_ratio_int, pll2_ratio_int;
	wire [27:0] pll1_ratio_num, pll2_ratio_num;
	wire [15:0] pll1_ratio_den, pll2_ratio_den;
	wire [2:0] pll1_interp_code, pll1_mash_code, pll2_interp_code, pll2_mash_code;
	typedef struct {string nm; logic [63:0] exp; int sel;} pfdc_note;
	pfdc_note notes[$];
	int failures = 0, total_checks = 0, nbits = 0;
	integer seed = 32'hc7ce;
	logic [7:0] cmd;
	logic [39:0] rdv, d, m;
	logic [39:0] shadow [6:9];
	event look;

	pfdc_top uut (.core_clk, .rst, .sclk, .cs_n, .mosi, .pll_power_down_pin, .pll2_locked,
		.serial_out_or_unlock_pin_o, .serial_out_or_unlock_pin_oe_n, .loss_of_lock_flag,
		.detector_pump_power_en, .oscillator_power_en, .feedback_div_power_en,
		.pll1_mode, .pll1_ratio_int, .pll1_ratio_num, .pll1_ratio_den, .pll1_exact_ratio,
		.pll1_interp_code, .pll1_mash_code, .pll1_bad_cfg, .pll2_mode, .pll2_ratio_int,
		.pll2_ratio_num, .pll2_ratio_den, .pll2_exact_ratio, .pll2_interp_code,
		.pll2_mash_code, .pll2_bad_cfg);

	// ------
	// models and helpers
	// ------
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// expected decode of one divider/mode register pair
	function automatic logic [63:0] dec(input logic [39:0] dv, input logic [39:0] mv);
		logic [27:0] f, n;
		logic [15:0] md, dn;
		logic [1:0] mo;
		logic [2:0] ic, mc;
		f = dv[31:4];
		md = {mv[9:0], f[5:0]};
		{ic, mc, n, dn} = '0;
		mo = mv[11] ? 2'h0 : (mv[10] && md != 16'h0000) ? 2'h2 : 2'h1;
		if (mo == 2'h0 && mv[17:16] == 2'h3) mc = f[27:25];
		else if (mo == 2'h0) ic = f[27:25];
		if (mo == 2'h2) {n, dn} = {12'h000, f[24:9], md};
		if (mo == 2'h1) n = f;
		return {2'h0, mo, dv[39:32], n, dn, mo == 2'h2 && mv[17:16] == 2'h3, ic, mc,
			dv[39:32] < 8'h17 || (mo == 2'h2 && n > {12'h000, dn})};
	endfunction
	// output snapshot matching a note kind
	function automatic logic [63:0] seen(input int sel);
		case (sel)
		0: return {61'h0, serial_out_or_unlock_pin_o, serial_out_or_unlock_pin_oe_n, loss_of_lock_flag};
		1: return {61'h0, detector_pump_power_en, oscillator_power_en, feedback_div_power_en};
		2: return {2'h0, pll2_mode, pll2_ratio_int, pll2_ratio_num, pll2_ratio_den, pll2_exact_ratio,
			pll2_interp_code, pll2_mash_code, pll2_bad_cfg};
		default: return {2'h0, pll1_mode, pll1_ratio_int, pll1_ratio_num, pll1_ratio_den, pll1_exact_ratio,
			pll1_interp_code, pll1_mash_code, pll1_bad_cfg};
		endcase
	endfunction
	task automatic take(input logic [63:0] obs);
		pfdc_note n;
		n = notes.pop_front();
		total_checks++;
		if (obs !== n.exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n.nm, n.exp, obs);
		end
	endtask
	// one serial bit: data set early, three cycles low then three high
	task automatic sbit(input logic b);
		mosi <= b;
		repeat (3) @(posedge core_clk);
		sclk <= 1'b1;
		repeat (3) @(posedge core_clk);
		sclk <= 1'b0;
	endtask
	task automatic frame(input logic r, input logic [6:0] a, input logic [39:0] v);
		logic [47:0] w;
		w = {r, a, v};
		cs_n <= 1'b0;
		for (int i = 47; i >= 0; i--) sbit(w[i]);
		repeat (3) @(posedge core_clk);
		cs_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
	// unmapped places read as zero and keep no write
	task automatic rd(input logic [6:0] a);
		notes.push_back('{"readback", (a > 7'h05 && a < 7'h0a) ? {24'h0, shadow[a]} : 64'h0, 9});
		frame(1'b1, a, $random(seed));
	endtask
	task automatic wr(input logic [6:0] a, input logic [39:0] v);
		if (a > 7'h05 && a < 7'h0a) shadow[a] = v;
		frame(1'b0, a, v);
	endtask
	task automatic look_at(input string nm, input logic [63:0] exp, input int sel);
		notes.push_back('{nm, exp, sel});
		repeat (2) @(posedge core_clk);
		#1 -> look;
		@(posedge core_clk);
	endtask
	task automatic chk(input int sel);
		look_at("decode", dec(shadow[sel == 2 ? 8 : 6], shadow[sel == 2 ? 9 : 7]), sel);
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// readback monitor: pin sampled at each sclk rise after the command byte
	always @(posedge core_clk) begin
		if (cs_n) nbits = 0;
		else if (sclk && !sclk_q) begin
			if (nbits < 8) cmd = {cmd[6:0], mosi};
			else rdv = {rdv[38:0], serial_out_or_unlock_pin_oe_n ? 1'bx : serial_out_or_unlock_pin_o};
			nbits++;
			if (nbits == 48 && cmd[7]) take({24'h0, rdv});
		end
		sclk_q = sclk;
	end
	// snapshot monitor for the settled pin, power or decoded outputs
	always @(look) take(seen(notes[0].sel));
	// a hang costs far more than the roughly 17k cycles the sequence needs
	initial begin
		#400_000;
		failures++;
		close_out;
	end

	// ------
	// sequence
	// ------
	initial begin
		int j;
		rst = 1'b1; sclk = 1'b0; cs_n = 1'b1; mosi = 1'b0;
		pll2_locked = 1'b1; pll_power_down_pin = 2'h0;
		shadow[6] = 40'h0; shadow[7] = 40'h0; shadow[8] = 40'h00_0000_000e; shadow[9] = 40'h0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// reset values, then an unmapped write and read
		for (int a = 6; a < 11; a++) rd(7'(a));
		wr(7'h0a, 40'hff_ffff_ffff);
		rd(7'h0a);
		chk(2);
		chk(3);
		look_at("power", 64'h7, 1);
		for (int i = 1; i < 4; i++) begin
			wr(7'h08, {shadow[8][39:4], 4'he ^ (4'h1 << i)});
			rd(7'h08);
			look_at("power", {61'h0, shadow[8][3:1]}, 1);
		end
		// the power-down pin wins over set bits
		wr(7'h08, 40'h00_0000_000e);
		pll_power_down_pin <= 2'h2;
		look_at("power", 64'h0, 1);
		pll_power_down_pin <= 2'h1;
		look_at("power", 64'h7, 1);
		// every mode and select, both PLLs, boundary integers and a numerator above modulus
		// host limits broken on purpose so the flag is exercised; shared bits stay random except in case 4, which zeroes them
		for (int k = 0; k < 20; k++) begin
			j = k % 10;
			d[39:8] = $random(seed);
			d[7:0] = $random(seed);
			d[39:32] = j == 9 ? 8'h16 : j == 0 ? 8'h17 : 8'h18 + d[38:32];
			d[3:0] = 4'he;
			m = {8'h0, $random(seed)};
			m[11] = j > 5;
			m[10] = j > 0 && j < 6;
			m[17:16] = j > 5 ? 2'(j - 6) : j == 5 ? 2'h0 : 2'h3;
			if (j == 1) m[9:0] = 10'h3ff;
			if (j == 2) m[9:0] = 10'h001;
			if (j == 4) {m[9:0], d[9:4]} = 16'h0000;
			wr(k < 10 ? 7'h08 : 7'h06, d);
			wr(k < 10 ? 7'h09 : 7'h07, m);
			chk(k < 10 ? 2 : 3);
		end
		// unlock function tracks the lock input
		wr(7'h08, 40'h00_0000_000f);
		for (int i = 0; i < 4; i++) begin
			pll2_locked <= i[0];
			look_at("pin", {61'h0, !i[0], 1'b0, !i[0]}, 0);
		end
		wr(7'h08, 40'h00_0000_000e);
		look_at("pin", 64'h2, 0);
		rd(7'h09);
		close_out;
	end
endmodule
`default_nettype wire
